// >>> logic/msat_top.sv
// Serial audio output of a digital microphone: I2S slave transmitter.
// Assumes bit clock, word select and strap arrive asynchronously on pins
// and that samples arrive on the system clock through a valid/ready port.
`timescale 1ns/1ps
`include "msat_params.svh"

module msat_top #(
    parameter int WORD_BITS = `MSAT_WORD_BITS,
    parameter int FIFO_DEPTH = `MSAT_FIFO_DEPTH,
    parameter int STARTUP_SCK = `MSAT_STARTUP_SCK,
    parameter int IDLE_CYCLES = `MSAT_IDLE_CYC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial bus pins.
    input wire logic sck_pin,
    input wire logic ws_pin,
    input wire logic channel_slot_strap,
    output logic sd_out,
    output logic sd_oe,
    // Sample stream from the decimator.
    input wire logic [WORD_BITS-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    // Status.
    output logic standby
);

    localparam int IW = $clog2(IDLE_CYCLES + 1);
    localparam int SW = $clog2(STARTUP_SCK + 1);
    localparam int BW = $clog2(WORD_BITS);
    localparam int PW = WORD_BITS + `MSAT_GAIN_BITS + 1;

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    generate
        if (WORD_BITS < 2 || STARTUP_SCK < 1 || IDLE_CYCLES < 2)
        begin : g_bad
            $error("msat_top: unsupported parameter values");
        end
    endgenerate

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire [`MSAT_SYNC_PINS-1:0] pins_w = {channel_slot_strap, ws_pin,
                                          sck_pin};
    logic [`MSAT_SYNC_PINS-1:0] s1_r;
    logic [`MSAT_SYNC_PINS-1:0] s2_r;
    logic sck_d_r;

    // Two flip-flops per pin before any logic looks at it.
    genvar gi;
    generate
        for (gi = 0; gi < `MSAT_SYNC_PINS; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pins_w[gi];
                    s2_r[gi] <= s1_r[gi];
                end
            end
        end
    endgenerate

    // Delayed bit clock for edge detection.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= s2_r[`MSAT_PIN_SCK];
        end
    end

    // Bit-clock edges, synchronised word select and strap.
    wire sck_w = s2_r[`MSAT_PIN_SCK];
    wire sck_rise = sck_w & ~sck_d_r;
    wire sck_fall = ~sck_w & sck_d_r;
    wire ws_s = s2_r[`MSAT_PIN_WS];
    wire strap_s = s2_r[`MSAT_PIN_STRAP];

    // ****************************************************************
    // Clock activity and power modes
    // ****************************************************************
    logic [IW-1:0] idle_r;
    logic standby_r;
    logic [SW-1:0] sck_cnt_r;
    msat_pkg::msat_mode_e mode_r;
    msat_pkg::msat_mode_e mode_nxt;

    // Counts system cycles since the last bit-clock edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idle_r <= IW'(IDLE_CYCLES);
            standby_r <= 1'b1;
        end else begin
            if (sck_rise | sck_fall) begin
                idle_r <= '0;
            end else if (idle_r != IW'(IDLE_CYCLES)) begin
                idle_r <= idle_r + 1'b1;
            end
            standby_r <= (idle_r == IW'(IDLE_CYCLES)); // RL4
        end
    end

    // Startup latency counter, restarted by every standby.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || standby_r) begin
            sck_cnt_r <= '0; // RL5
        end else if (sck_rise && sck_cnt_r != SW'(STARTUP_SCK)) begin
            sck_cnt_r <= sck_cnt_r + 1'b1; // RL2
        end
    end

    // Mode sequence: standby, wake with zero output, then run.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            msat_pkg::MSAT_MODE_STANDBY:
                mode_nxt = msat_pkg::MSAT_MODE_WAKE;
            msat_pkg::MSAT_MODE_WAKE:
                if (sck_cnt_r == SW'(STARTUP_SCK)) begin
                    mode_nxt = msat_pkg::MSAT_MODE_RUN; // RL2
                end
            msat_pkg::MSAT_MODE_RUN:
                mode_nxt = msat_pkg::MSAT_MODE_RUN; // RL3
            default:
                mode_nxt = msat_pkg::MSAT_MODE_STANDBY;
        endcase
        if (standby_r) begin
            mode_nxt = msat_pkg::MSAT_MODE_STANDBY; // RL4
        end
    end

    // Mode register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_r <= msat_pkg::MSAT_MODE_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    wire live_w = (mode_r == msat_pkg::MSAT_MODE_RUN);

    // ****************************************************************
    // Frame alignment and slot selection
    // ****************************************************************
    logic ws_last_r;
    logic aligned_r;
    logic start_r;
    msat_pkg::msat_gain_t gain_r;

    // Half-frame starts seen at rising bit-clock edges.
    wire ws_edge = sck_rise & (ws_s != ws_last_r); // RL16
    wire slot_hit = ws_edge & (ws_s == strap_s); // RL1 RL11
    wire load_slot = slot_hit & aligned_r & ~standby_r; // RL8

    // Word-select history; the first change after wake is flushed.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ws_last_r <= 1'b0;
            aligned_r <= 1'b0;
        end else begin
            if (sck_rise) begin
                ws_last_r <= ws_s;
            end
            if (standby_r) begin
                aligned_r <= 1'b0;
            end else if (ws_edge) begin
                aligned_r <= 1'b1; // RL8
            end
        end
    end

    // ****************************************************************
    // Sample buffer and soft unmute
    // ****************************************************************
    wire [WORD_BITS-1:0] fifo_data;
    wire fifo_valid;
    logic signed [PW-1:0] prod_w;
    logic [WORD_BITS-1:0] word_w;

    msat_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_data(sample_data),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(load_slot)
    );

    // Gain scaling; an empty buffer or the wake phase sends zero.
    assign prod_w = $signed(fifo_data) * $signed({1'b0, gain_r}); // RL7
    assign word_w = (live_w && fifo_valid) ?
                    prod_w[`MSAT_GAIN_SHIFT +: WORD_BITS] : '0; // RL2

    // Gain rises by one step per own-slot word in run mode until full scale.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || standby_r) begin
            gain_r <= '0;
        end else if (load_slot && live_w &&
                     gain_r != `MSAT_GAIN_BITS'(`MSAT_RAMP_FRAMES)) begin
            gain_r <= gain_r + 1'b1; // RL7
        end
    end

    // ****************************************************************
    // Serial shifter
    // ****************************************************************
    logic [WORD_BITS-1:0] shift_r;
    logic [BW-1:0] left_r;
    logic sd_out_r;
    logic sd_oe_r;

    // Loads on the slot start, shifts on each falling bit-clock edge while the word goes out.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_r <= '0;
            start_r <= 1'b0;
            left_r <= '0;
        end else if (load_slot) begin
            shift_r <= word_w; // RL9
            start_r <= 1'b1;
        end else if (sck_fall && (start_r || sd_oe_r)) begin
            shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
            start_r <= 1'b0;
            left_r <= start_r ? BW'(WORD_BITS - 1) : left_r - 1'b1;
        end
    end

    // Line driver: drives its own slot and releases after the last bit.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || standby_r) begin
            sd_out_r <= 1'b0;
            sd_oe_r <= 1'b0; // RL13
        end else if (sck_fall && start_r) begin
            sd_out_r <= shift_r[WORD_BITS-1]; // RL15 RL16
            sd_oe_r <= 1'b1;
        end else if (sck_fall && sd_oe_r) begin
            sd_out_r <= (left_r != '0) & shift_r[WORD_BITS-1];
            sd_oe_r <= (left_r != '0); // RL12
        end
    end

    assign sd_out = sd_out_r;
    assign sd_oe = sd_oe_r;
    assign standby = standby_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [BW:0] drv_cnt_r;

    // Counts falling edges spent driving, for the word-length check.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drv_cnt_r <= '0;
        end else if (sck_fall) begin
            drv_cnt_r <= sd_oe_r ? drv_cnt_r + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    slot_select_a: assert property ( // RL1
        $rose(sd_oe_r) |-> ws_s == strap_s)
        else $error("word started in the wrong slot");
    zero_startup_a: assert property ( // RL2
        load_slot && !live_w |=> shift_r == '0)
        else $error("non-zero word before startup completed");
    standby_idle_a: assert property ( // RL4
        idle_r == IW'(IDLE_CYCLES) |=> standby_r)
        else $error("no standby after bit clock stopped");
    restart_a: assert property ( // RL5
        standby_r |=> sck_cnt_r == '0 && gain_r == '0 && !live_w)
        else $error("startup state not restarted by standby");
    gain_step_a: assert property ( // RL7
        load_slot && live_w && gain_r < `MSAT_GAIN_BITS'(`MSAT_RAMP_FRAMES)
        |=> gain_r == $past(gain_r) + 1'b1)
        else $error("gain ramp did not advance");
    align_first_a: assert property ( // RL8
        standby_r |=> !aligned_r && !load_slot)
        else $error("word loaded before alignment");
    word_len_a: assert property ( // RL9
        $fell(sd_oe_r) && !$past(standby_r) |-> drv_cnt_r == (BW+1)'(24))
        else $error("driven word is not 24 bits long");
    release_a: assert property ( // RL12
        sck_fall && sd_oe_r && left_r == '0 && !start_r |=> !sd_oe_r)
        else $error("line not released after last bit");
    idle_hiz_a: assert property ( // RL13
        standby_r |=> !sd_oe_r)
        else $error("line driven during standby");
    msb_first_a: assert property ( // RL15
        sck_fall && start_r && !standby_r
        |=> sd_oe_r && sd_out_r == $past(shift_r[WORD_BITS-1]))
        else $error("first bit is not the most significant bit");
    fall_change_a: assert property ( // RL16
        $changed(sd_out_r) && !$past(standby_r) |-> $past(sck_fall))
        else $error("data changed away from a falling bit-clock edge");

    live_word_c: cover property (load_slot && live_w && fifo_valid);
    standby_c: cover property ($rose(standby_r));
    full_gain_c: cover property (
        gain_r == `MSAT_GAIN_BITS'(`MSAT_RAMP_FRAMES));
    rewake_c: cover property ($fell(standby_r) ##[1:1000] $rose(sd_oe_r));

endmodule // msat_top

// >>> logic/msat_params.svh
// Constants of the serial audio transmitter: widths, counts and timing.
// Assumes inclusion by bare name from the package and the top module.
// Function
// RL1: Strap low selects the left slot, strap high selects the right slot.
// RL2: Only zero samples until 4462 bit-clock cycles have passed.
// RL3: Normal operation while bit clock and word select both toggle.
// RL4: Standby when the bit clock falls below about one kilohertz; code waits 1000 us without any bit-clock edge, so about 500 Hz.
// RL5: Leaving standby repeats the full power-up startup latency.
// RL6: Master should stop both clocks low to enter standby.
// RL7: Gain ramps from mute to full scale over 256 word-select periods.
// RL8: Output aligns to word select, flushing one half-frame after enable.
// RL9: Slave output of 24-bit twos-complement words in I2S format.
// RL10: Master provides exactly 64 bit-clock cycles per stereo frame.
// RL11: Left slot starts after word-select fall, right after its rise.
// RL12: Data line released right after the least significant bit.
// RL13: Data line stays released outside the device's own slot.
// RL14: System holds the configuration strap low at power-up.
// RL15: Most significant bit first, one bit clock after word-select change.
// RL16: Data changes on bit-clock falls, word select sampled on rises.
`ifndef MSAT_PARAMS_SVH
`define MSAT_PARAMS_SVH

// ****************************************************************
// Data path
// ****************************************************************
`define MSAT_WORD_BITS 24
`define MSAT_FIFO_DEPTH 32
`define MSAT_SYNC_PINS 3
`define MSAT_PIN_SCK 0
`define MSAT_PIN_WS 1
`define MSAT_PIN_STRAP 2

// ****************************************************************
// Timing
// ****************************************************************
`define MSAT_SYS_CLK_MHZ 25
`define MSAT_STARTUP_SCK 4462
`define MSAT_STANDBY_PERIOD_US 1000
`define MSAT_IDLE_CYC (`MSAT_SYS_CLK_MHZ * `MSAT_STANDBY_PERIOD_US)
`define MSAT_RAMP_FRAMES 256
`define MSAT_GAIN_SHIFT 8
`define MSAT_GAIN_BITS 9

`endif

// >>> logic/msat_pkg.sv
// Types shared by the serial audio transmitter modules.
// Assumes msat_params.svh is on the include path.
`include "msat_params.svh"

package msat_pkg;

    // ****************************************************************
    // Operating modes
    // ****************************************************************
    typedef enum logic [1:0] {
        MSAT_MODE_STANDBY,
        MSAT_MODE_WAKE,
        MSAT_MODE_RUN
    } msat_mode_e;

    typedef logic [`MSAT_GAIN_BITS-1:0] msat_gain_t;

endpackage

// >>> logic/msat_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps

module msat_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Filling side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("msat_fifo: DEPTH must be a power of two of 2 or more");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic [WIDTH-1:0] out_data_r;
    logic out_valid_r;
    logic in_ready_r;

    // Handshakes, next pointers and the next fill level.
    wire push_w = in_valid & in_ready_r;
    wire pop_w = out_valid_r & out_ready;
    wire [AW-1:0] rd_nxt = rd_r + AW'(pop_w);
    wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
    wire bypass_w = push_w & (wr_r == rd_nxt);

    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // Storage write.
    always_ff @(posedge clk) begin
        if (push_w) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers, level flags and the registered head word.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            out_valid_r <= 1'b0;
            in_ready_r <= 1'b1;
            out_data_r <= '0;
        end else begin
            wr_r <= wr_r + AW'(push_w);
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            out_valid_r <= (cnt_nxt != '0);
            in_ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
            out_data_r <= bypass_w ? in_data : mem_r[rd_nxt];
        end
    end

endmodule // msat_fifo

// >>> tb/msat_i2s_master.sv
// Behavioural I2S bus master: makes bit clock and word select, reads words.
// Assumes the bench resolves the shared data wire with a pull-down.
`timescale 1ns/1ps

module msat_i2s_master #(
    parameter int HALF_NS = 160
) (
    // Control from the bench.
    input wire logic run,
    // Bus pins.
    output logic sck,
    output logic ws,
    input wire logic sd,
    // One result per half-frame.
    output logic done,
    output logic slot,
    output logic [23:0] word,
    output logic [7:0] tail,
    output logic [7:0] glitches
);
    logic [31:0] shift;
    logic early;

    // ***********
    // Frame engine
    // ***********
    // Bits are read late in the high phase to allow for the slave's
    // synchroniser, and once early to see that the bit held still.
    initial begin
        sck = 1'b0;
        ws = 1'b0;
        done = 1'b0;
        slot = 1'b0;
        word = 24'h000000;
        tail = 8'h00;
        glitches = 8'h00;
        shift = 32'h00000000;
        #7;
        forever begin
            if (!run) begin
                sck = 1'b0;
                ws = 1'b0;
                wait (run);
            end
            for (int h = 0; h < 2; h++) begin
                glitches = 8'h00;
                for (int i = 0; i < 32; i++) begin
                    sck = 1'b0;
                    if (i == 0) begin
                        ws = h[0];
                    end
                    #(HALF_NS);
                    sck = 1'b1;
                    #20;
                    early = sd;
                    #(HALF_NS - 30);
                    if (sd !== early) begin
                        glitches++;
                    end
                    shift = {shift[30:0], sd};
                    if (i == 31) begin
                        slot = h[0];
                        word = shift[30:7];
                        tail = {shift[31], shift[6:0]};
                        done = 1'b1;
                    end
                    #10;
                    done = 1'b0;
                end
            end
        end
    end
endmodule // msat_i2s_master

// >>> tb/msat_top_tb_top.sv
// Bench for the serial audio transmitter: slots, startup, ramp, standby.
// Assumes the master model msat_i2s_master drives the serial bus.
`timescale 1ns/1ps

module msat_top_tb_top;
    localparam int STARTUP = 200;
    localparam int IDLE = 64;
    localparam int STEPS = 40;
    logic sys_clk, rst_n, run, strap, valid, ready, standby;
    logic sck, ws, sd_out, sd_oe, sd_wire, done, slot, live;
    logic [23:0] data, word, s_val;
    logic [7:0] tail, glitches;
    logic [31:0] seed, zeros, oe_cnt, last_own, n;
    logic [31:0] exp_q[$];
    int miscompares, samples_checked;

    // Released line falls to the pull-down level.
    assign sd_wire = (sd_oe === 1'b1) ? sd_out : 1'b0;

    msat_top #(.STARTUP_SCK(STARTUP), .IDLE_CYCLES(IDLE)) i_msat_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .sck_pin(sck), .ws_pin(ws),
        .channel_slot_strap(strap), .sd_out(sd_out), .sd_oe(sd_oe),
        .sample_data(data), .sample_valid(valid), .sample_ready(ready),
        .standby(standby));

    msat_i2s_master #(.HALF_NS(160)) i_msat_i2s_master (
        .run(run), .sck(sck), .ws(ws), .sd(sd_wire), .done(done),
        .slot(slot), .word(word), .tail(tail), .glitches(glitches));

    // ***********
    // Helpers
    // ***********
    // The system clock runs at 25 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Fills the FIFO in standby, notes the ramp and starts the master.
    task automatic start_run(input logic side);
        seed = xs(seed);
        s_val = {2'b01, seed[21:0]};
        data = s_val;
        strap = side;
        live = 1'b0;
        zeros = 0;
        for (int g = 1; g <= STEPS; g++) begin
            exp_q.push_back(({8'h00, s_val} * g) >> 8);
        end
        valid = 1'b1;
        n = 0;
        while (ready === 1'b1 && n < 64) begin
            @(negedge sys_clk);
            n++;
        end
        check(n, 32);
        run = 1'b1;
        n = 0;
        while (standby !== 1'b0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(standby, 0);
        n = 0;
        while (exp_q.size() > 0 && n < 40000) begin
            @(negedge sys_clk);
            n++;
        end
        check(exp_q.size(), 0);
    endtask

    // ***********
    // Watchers
    // ***********
    // Counts the system cycles in which the device drives the line.
    // Sampled on the falling edge, away from the edge that moves sd_oe.
    always @(negedge sys_clk) begin
        if (sd_oe === 1'b1) begin
            oe_cnt++;
        end
    end

    // Compares each half-frame that the master read with the notes.
    always @(posedge done) begin
        if (slot !== strap) begin
            check(word, 0);
            check(oe_cnt, 0);
        end else if (!live && word === 24'h000000) begin
            zeros++;
        end else begin
            if (!live) begin
                check(zeros >= STARTUP / 64 + 1, 1);
                check(zeros <= STARTUP / 64 + 4, 1);
            end
            live = 1'b1;
            last_own = word;
            if (exp_q.size() > 0) begin
                check(word, exp_q.pop_front());
                check(oe_cnt, 24 * 8);
            end
        end
        check(tail, 0);
        check(glitches, 0);
        oe_cnt = 0;
    end

    // ***********
    // Sequence
    // ***********
    // Left slot run, drain, standby, then right slot run after wake.
    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        strap = 1'b0;
        valid = 1'b0;
        data = 24'h000000;
        seed = 32'h62D87276;
        oe_cnt = 0;
        live = 1'b0;
        zeros = 0;
        last_own = 0;
        miscompares = 0;
        samples_checked = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check(standby, 1);
        check(sd_oe, 0);
        start_run(1'b0);
        valid = 1'b0;
        repeat (36 * 512) @(negedge sys_clk);
        check(last_own, 0);
        check(ready, 1);
        run = 1'b0;
        n = 0;
        while (standby !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        check(n > IDLE, 1);
        check(n <= 512 + IDLE + 8, 1);
        check(sd_oe, 0);
        start_run(1'b1);
        end_of_test;
    end

    // Cuts a hang short.
    initial begin
        #(100000 * 40);
        miscompares++;
        end_of_test;
    end
endmodule // msat_top_tb_top
